// [hdl/mft_pkg.sv]
// Purpose: Constants for the dual down-counting timer register block
// Assumes: 16-bit register port, byte offsets as low address byte
// Notes:   Field positions and reset values live here only
//
// Functional notes
// - Counts and reloads keep value through reset
// - Reload A for counter one (PWM mode alternates A, B), B for two
// - Mode field picks PWM, capture, dual, reserved
// - Edge bit: 0 falling, 1 rising pin edges
// - Capture mode pin edge presets counter one when pin enable is set
// - Pin enable gives PWM output except in capture mode, clear frees pin
// - Data bit tracks PWM pin, software accessible
// - Software write of data bit beats hardware
// - Data bit ignored while pin is input
// - Disabled timer stops clocks, blocks data writes
// - Disable clears prescaler, pendings, pin to input
// - Mode and interrupt control reset to zero
// - Enables D..A bits 7..4, pendings 3..0
// - Pending set by event or software one
// - Software zero to pending flag is ignored
// - Enabled source requests interrupt, disabled never
// - Clear register bits 0..3 clear A..D
// - Clear register always reads all ones
// - Counters decrement, reload on underflow, continue; counter one wraps in capture and reserved modes
// - A, B, C to request one, D two
// - PWM pin toggles on counter one underflow
package mft_pkg;

   localparam int AW = 8;
   localparam int DW = 16;
   localparam int PSW = 5;
   localparam int CSW = 3;
   localparam int NSRC = 4;

   localparam logic [AW-1:0] OFS_CNT1  = 8'h40;
   localparam logic [AW-1:0] OFS_RLDA  = 8'h42;
   localparam logic [AW-1:0] OFS_RLDB  = 8'h44;
   localparam logic [AW-1:0] OFS_CNT2  = 8'h46;
   localparam logic [AW-1:0] OFS_PRSC  = 8'h48;
   localparam logic [AW-1:0] OFS_CKSEL = 8'h4a;
   localparam logic [AW-1:0] OFS_MODE  = 8'h4c;
   localparam logic [AW-1:0] OFS_ICTL  = 8'h4e;
   localparam logic [AW-1:0] OFS_ICLR  = 8'h50;

   localparam int BIT_TEN  = 7;
   localparam int BIT_OUT  = 6;
   localparam int BIT_PEN  = 4;
   localparam int BIT_EDGE = 2;
   localparam int MODE_LSB = 0;
   localparam int CK1_LSB  = 0;
   localparam int CK2_LSB  = 3;
   localparam int IEN_LSB  = 4;
   localparam int SRC_A    = 0;
   localparam int SRC_B    = 1;
   localparam int SRC_C    = 2;
   localparam int SRC_D    = 3;

   localparam logic [7:0]     MODE_MASK  = 8'hd7;
   localparam logic [7:0]     MODE_RST   = 8'h00;
   localparam logic [7:0]     ICTL_RST   = 8'h00;
   localparam logic [PSW-1:0] PRSC_RST   = 5'h00;
   localparam logic [5:0]     CKSEL_RST  = 6'h00;
   localparam logic [7:0]     CLR_READ   = 8'hff;
   localparam logic [DW-1:0]  CNT_PRESET = 16'hffff;
   localparam logic [DW-1:0]  CNT_ZERO   = 16'h0000;
   localparam logic [DW-1:0]  RD_NONE    = 16'h0000;

   localparam logic [CSW-1:0] CK_PRSC = 3'h1;
   localparam logic [CSW-1:0] CK_SLOW = 3'h4;

   typedef enum logic [1:0] {
      MFT_PWM  = 2'b00,
      MFT_CAP  = 2'b01,
      MFT_DUAL = 2'b10,
      MFT_RSV  = 2'b11
   } mft_mode_e;

endpackage

// [hdl/mft_timer.sv]
// Purpose: Dual 16-bit down counter with capture, PWM pin and interrupts
// Assumes: Single clock clk_sys at 40 MHz, async active-high reset
// Notes:   Pin and slow clock inputs pass three-stage synchronisers
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module mft_timer (
   input  wire logic                   clk_sys,
   input  wire logic                   reset,
   input  wire logic [mft_pkg::AW-1:0] reg_addr,
   input  wire logic [mft_pkg::DW-1:0] reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output      logic [mft_pkg::DW-1:0] reg_rdata,
   input  wire logic                   slow_clk_in,
   input  wire logic                   timer_pin_a_in,
   output      logic                   timer_pin_a_out,
   output      logic                   timer_pin_a_oe_n,
   output      logic                   timer_irq_1,
   output      logic                   timer_irq_2
);
   import mft_pkg::*;

   function automatic logic sel_tick(input logic [CSW-1:0] sel,
                                     input logic ptick,
                                     input logic stick);
      logic t;
      t = 1'b0;
      if (sel == CK_PRSC) begin
         t = ptick;
      end else if (sel == CK_SLOW) begin
         t = stick;
      end
      return t;
   endfunction

   function automatic logic [DW-1:0] dec16(input logic [DW-1:0] v);
      return DW'(v - 1'b1);
   endfunction

   function automatic logic hit(input logic [AW-1:0] a,
                                input logic [AW-1:0] ofs);
      return a == ofs;
   endfunction

   // Synchroniser state
   logic [2:0]      pin_s_r;
   logic [2:0]      pin_s_nxt;
   logic            pin_st_r;
   logic            pin_st_nxt;
   logic [2:0]      slw_s_r;
   logic [2:0]      slw_s_nxt;
   logic            slw_st_r;
   logic            slw_st_nxt;
   // Control state
   logic [7:0]      ctl_r;
   logic [7:0]      ctl_nxt;
   logic [PSW-1:0]  prsc_val_r;
   logic [PSW-1:0]  prsc_val_nxt;
   logic [5:0]      cksel_r;
   logic [5:0]      cksel_nxt;
   logic [PSW-1:0]  prsc_cnt_r;
   logic [PSW-1:0]  prsc_cnt_nxt;
   logic [NSRC-1:0] ien_r;
   logic [NSRC-1:0] ien_nxt;
   logic [NSRC-1:0] pend_r;
   logic [NSRC-1:0] pend_nxt;
   logic            phase_r;
   logic            phase_nxt;
   logic [DW-1:0]   rdata_r;
   logic [DW-1:0]   rdata_nxt;
   // Data state, no reset
   logic [DW-1:0]   cnt1_r;
   logic [DW-1:0]   cnt1_nxt;
   logic [DW-1:0]   cnt2_r;
   logic [DW-1:0]   cnt2_nxt;
   logic [DW-1:0]   rlda_r;
   logic [DW-1:0]   rlda_nxt;
   logic [DW-1:0]   rldb_r;
   logic [DW-1:0]   rldb_nxt;
   // Decoded terms
   logic            timer_enable_bit;
   logic            pen;
   mft_mode_e       mode;
   logic            pwm_on;
   logic            pin_evt;
   logic            slw_tick;
   logic            prsc_tick;
   logic            tick1;
   logic            tick2;
   logic            uf1;
   logic            uf2;
   logic            cap_evt;
   logic [NSRC-1:0] hw_ev;
   logic [NSRC-1:0] sw_set;
   logic [NSRC-1:0] sw_clr;
   logic            wr_mode;
   logic [DW-1:0]   rd_val;

   assign timer_enable_bit  = ctl_r[BIT_TEN];
   assign pen  = ctl_r[BIT_PEN];
   assign mode = mft_mode_e'(ctl_r[MODE_LSB +: 2]);
   assign wr_mode = reg_wr && hit(reg_addr, OFS_MODE);

   // Pin drives only as PWM output, input otherwise
   assign pwm_on = timer_enable_bit && pen && (mode != MFT_CAP);
   assign timer_pin_a_oe_n = !pwm_on;
   assign timer_pin_a_out  = pwm_on && ctl_r[BIT_OUT];

   // Synchronisers: change taken when stages two and three agree
   always_comb begin
      pin_s_nxt  = {pin_s_r[1:0], timer_pin_a_in};
      slw_s_nxt  = {slw_s_r[1:0], slow_clk_in};
      pin_st_nxt = pin_st_r;
      slw_st_nxt = slw_st_r;
      if (pin_s_r[1] == pin_s_r[2]) begin
         pin_st_nxt = pin_s_r[2];
      end
      if (slw_s_r[1] == slw_s_r[2]) begin
         slw_st_nxt = slw_s_r[2];
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pin_s_r  <= 3'h0;
         pin_st_r <= 1'b0;
         slw_s_r  <= 3'h0;
         slw_st_r <= 1'b0;
      end else begin
         pin_s_r  <= pin_s_nxt;
         pin_st_r <= pin_st_nxt;
         slw_s_r  <= slw_s_nxt;
         slw_st_r <= slw_st_nxt;
      end
   end

   // Qualifying pin edge per polarity bit
   always_comb begin
      if (ctl_r[BIT_EDGE]) begin
         pin_evt = pin_st_nxt && !pin_st_r;
      end else begin
         pin_evt = !pin_st_nxt && pin_st_r;
      end
   end

   assign slw_tick  = slw_st_nxt && !slw_st_r;
   assign prsc_tick = timer_enable_bit && (prsc_cnt_r == prsc_val_r);
   // Counter clocks stop while disabled
   assign tick1 = timer_enable_bit && sel_tick(cksel_r[CK1_LSB +: CSW], prsc_tick, slw_tick);
   assign tick2 = timer_enable_bit && sel_tick(cksel_r[CK2_LSB +: CSW], prsc_tick, slw_tick);
   assign uf1 = tick1 && (cnt1_r == CNT_ZERO);
   assign uf2 = tick2 && (cnt2_r == CNT_ZERO);
   assign cap_evt = timer_enable_bit && (mode == MFT_CAP) && pin_evt;

   // Hardware interrupt events per mode
   always_comb begin
      hw_ev = '0;
      unique case (mode)
         MFT_PWM: begin
            hw_ev[SRC_A] = uf1 && !phase_r;
            hw_ev[SRC_B] = uf1 && phase_r;
            hw_ev[SRC_D] = uf2;
         end
         MFT_CAP: begin
            hw_ev[SRC_A] = cap_evt;
            hw_ev[SRC_C] = uf1;
            hw_ev[SRC_D] = uf2;
         end
         MFT_DUAL: begin
            hw_ev[SRC_A] = uf1;
            hw_ev[SRC_D] = uf2;
         end
         MFT_RSV: begin
            hw_ev = '0;
         end
      endcase
   end

   // Control registers and prescaler
   always_comb begin
      ctl_nxt      = ctl_r;
      prsc_val_nxt = prsc_val_r;
      cksel_nxt    = cksel_r;
      prsc_cnt_nxt = prsc_cnt_r;
      phase_nxt    = phase_r;
      if (pwm_on && uf1) begin
         ctl_nxt[BIT_OUT] = !ctl_r[BIT_OUT];
      end
      if (mode == MFT_PWM && uf1) begin
         phase_nxt = !phase_r;
      end
      if (wr_mode) begin
         ctl_nxt = reg_wdata[7:0] & MODE_MASK;
      end
      if (reg_wr && hit(reg_addr, OFS_PRSC)) begin
         prsc_val_nxt = reg_wdata[PSW-1:0];
      end
      if (reg_wr && hit(reg_addr, OFS_CKSEL)) begin
         cksel_nxt = reg_wdata[5:0];
      end
      if (!timer_enable_bit || prsc_tick) begin
         prsc_cnt_nxt = PRSC_RST;
      end else begin
         prsc_cnt_nxt = PSW'(prsc_cnt_r + 1'b1);
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctl_r      <= MODE_RST;
         prsc_val_r <= PRSC_RST;
         cksel_r    <= CKSEL_RST;
         prsc_cnt_r <= PRSC_RST;
         phase_r    <= 1'b0;
      end else begin
         ctl_r      <= ctl_nxt;
         prsc_val_r <= prsc_val_nxt;
         cksel_r    <= cksel_nxt;
         prsc_cnt_r <= prsc_cnt_nxt;
         phase_r    <= phase_nxt;
      end
   end

   // Interrupt enables and pending flags
   always_comb begin
      ien_nxt = ien_r;
      sw_set  = '0;
      sw_clr  = '0;
      if (reg_wr && hit(reg_addr, OFS_ICTL)) begin
         ien_nxt = reg_wdata[IEN_LSB +: NSRC];
         sw_set  = timer_enable_bit ? reg_wdata[NSRC-1:0] : '0;
      end
      if (reg_wr && hit(reg_addr, OFS_ICLR)) begin
         sw_clr = reg_wdata[NSRC-1:0];
      end
      if (!timer_enable_bit) begin
         pend_nxt = '0;
      end else begin
         pend_nxt = (pend_r & ~sw_clr) | hw_ev | sw_set;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ien_r  <= ICTL_RST[IEN_LSB +: NSRC];
         pend_r <= ICTL_RST[NSRC-1:0];
      end else begin
         ien_r  <= ien_nxt;
         pend_r <= pend_nxt;
      end
   end

   // Requests follow pending and enable
   assign timer_irq_1 = |(pend_r[SRC_C:SRC_A] & ien_r[SRC_C:SRC_A]);
   assign timer_irq_2 = pend_r[SRC_D] && ien_r[SRC_D];

   // Counters and reload registers
   always_comb begin
      cnt1_nxt = cnt1_r;
      cnt2_nxt = cnt2_r;
      rlda_nxt = rlda_r;
      rldb_nxt = rldb_r;
      if (tick1) begin
         if (!uf1 || mode == MFT_CAP || mode == MFT_RSV) begin
            cnt1_nxt = dec16(cnt1_r);
         end else if (mode == MFT_PWM && phase_r) begin
            cnt1_nxt = rldb_r;
         end else begin
            cnt1_nxt = rlda_r;
         end
      end
      if (tick2) begin
         cnt2_nxt = uf2 ? rldb_r : dec16(cnt2_r);
      end
      if (cap_evt) begin
         rlda_nxt = cnt1_r;
         if (pen) begin
            cnt1_nxt = CNT_PRESET;
         end
      end
      if (reg_wr && timer_enable_bit) begin
         if (hit(reg_addr, OFS_CNT1)) begin
            cnt1_nxt = reg_wdata;
         end
         if (hit(reg_addr, OFS_CNT2)) begin
            cnt2_nxt = reg_wdata;
         end
         if (hit(reg_addr, OFS_RLDA)) begin
            rlda_nxt = reg_wdata;
         end
         if (hit(reg_addr, OFS_RLDB)) begin
            rldb_nxt = reg_wdata;
         end
      end
   end

   // No reset: contents survive reset
   always_ff @(posedge clk_sys) begin
      cnt1_r <= cnt1_nxt;
      cnt2_r <= cnt2_nxt;
      rlda_r <= rlda_nxt;
      rldb_r <= rldb_nxt;
   end

   // Read mux, data in the cycle after the strobe
   always_comb begin
      rd_val = RD_NONE;
      unique case (reg_addr)
         OFS_CNT1:  rd_val = cnt1_r;
         OFS_CNT2:  rd_val = cnt2_r;
         OFS_RLDA:  rd_val = rlda_r;
         OFS_RLDB:  rd_val = rldb_r;
         OFS_PRSC:  rd_val = DW'(prsc_val_r);
         OFS_CKSEL: rd_val = DW'(cksel_r);
         OFS_MODE:  rd_val = DW'(ctl_r);
         OFS_ICTL:  rd_val = DW'({ien_r, pend_r});
         OFS_ICLR:  rd_val = DW'(CLR_READ);
         default:   rd_val = RD_NONE;
      endcase
      rdata_nxt = reg_rd ? rd_val : RD_NONE;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rdata_r <= RD_NONE;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   a_clr_reads_ones: assert property (
      reg_rd && reg_addr == OFS_ICLR |=> reg_rdata == DW'(CLR_READ))
      else $error("clear register read not all ones");

   a_off_no_pend: assert property (
      !timer_enable_bit |=> pend_r == '0)
      else $error("pending flags survive disable");

   a_off_pin_in: assert property (
      !timer_enable_bit |-> timer_pin_a_oe_n)
      else $error("pin driven while disabled");

   a_off_cnt_hold: assert property (
      !timer_enable_bit && reg_wr && reg_addr == OFS_CNT1 |=> $stable(cnt1_r))
      else $error("counter written while disabled");

   a_zero_ignored: assert property (
      timer_enable_bit && pend_r[SRC_A] && reg_wr && reg_addr == OFS_ICTL
      && !reg_wdata[SRC_A] |=> pend_r[SRC_A])
      else $error("software zero cleared a pending flag");

   a_clr_works: assert property (
      reg_wr && reg_addr == OFS_ICLR && reg_wdata[SRC_B]
      && !hw_ev[SRC_B] |=> !pend_r[SRC_B])
      else $error("clear register did not clear flag");

   a_set_beats_clr: assert property (
      timer_enable_bit && hw_ev[SRC_D] && reg_wr && reg_addr == OFS_ICLR |=> pend_r[SRC_D])
      else $error("event lost against clear");

   a_irq_one: assert property (
      pend_r[SRC_B] && ien_r[SRC_B] |-> timer_irq_1)
      else $error("request one missing");

   a_irq_two_off: assert property (
      !ien_r[SRC_D] |-> !timer_irq_2)
      else $error("request two without enable");

   a_cap_preset: assert property (
      cap_evt && pen && !(reg_wr && reg_addr == OFS_CNT1) |=> cnt1_r == CNT_PRESET)
      else $error("capture did not preset counter one");

   a_sw_out_wins: assert property (
      wr_mode |=> ctl_r[BIT_OUT] == $past(reg_wdata[BIT_OUT]))
      else $error("software data bit lost");

   a_pwm_toggle: assert property (
      pwm_on && uf1 && !wr_mode |=> timer_pin_a_out != $past(timer_pin_a_out))
      else $error("pin did not toggle on underflow");

   c_capture: cover property (cap_evt && pen);
   c_toggle: cover property (pwm_on && uf1);
   c_irq1: cover property ($rose(timer_irq_1));
   c_disable: cover property ($fell(timer_enable_bit) && pend_r != '0);

endmodule

// [sim/tb_mft_timer.sv]
// Purpose: Self-checking bench for the dual timer register block
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Bench drives pin and slow clock itself, no partner model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_mft_timer;
   import mft_pkg::*;

   logic          clk_sys;
   logic          reset;
   logic [AW-1:0] reg_addr;
   logic [DW-1:0] reg_wdata;
   logic          reg_wr;
   logic          reg_rd;
   logic [DW-1:0] reg_rdata;
   logic          slow_clk_in;
   logic          timer_pin_a_in;
   logic          timer_pin_a_out;
   logic          timer_pin_a_oe_n;
   logic          timer_irq_1;
   logic          timer_irq_2;
   logic [DW-1:0] v;
   logic [3:0]    pend;
   int            fail_count;
   int            checks_done;

   mft_timer dut (
      .clk_sys          (clk_sys),
      .reset            (reset),
      .reg_addr         (reg_addr),
      .reg_wdata        (reg_wdata),
      .reg_wr           (reg_wr),
      .reg_rd           (reg_rd),
      .reg_rdata        (reg_rdata),
      .slow_clk_in      (slow_clk_in),
      .timer_pin_a_in   (timer_pin_a_in),
      .timer_pin_a_out  (timer_pin_a_out),
      .timer_pin_a_oe_n (timer_pin_a_oe_n),
      .timer_irq_1      (timer_irq_1),
      .timer_irq_2      (timer_irq_2)
   );

   initial begin
      clk_sys = 1'b0;
      reset = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      slow_clk_in = 1'b0;
      timer_pin_a_in = 1'b0;
      fail_count = 0;
      checks_done = 0;
   end

   always #12.5 clk_sys = ~clk_sys;

   // Slow clock, one rising edge every 20 system cycles
   always begin
      repeat (10) @(posedge clk_sys);
      slow_clk_in <= ~slow_clk_in;
   end

   task automatic do_reset();
      reset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic chk_rd(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] e);
      logic [DW-1:0] d;
      rd(a, d);
      `CHK(nm, e, d)
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wait_pin(input logic lvl);
      int n;
      for (n = 0; n < 400 && timer_pin_a_out !== lvl; n++)
         @(posedge clk_sys);
      checks_done++;
      if (timer_pin_a_out !== lvl) begin
         fail_count++;
         $display("BAD pin_wait exp %h got %h", lvl, timer_pin_a_out);
         tally_and_finish();
      end
   endtask

   // Writes counter one, moves the pin, expects counter one afterwards
   task automatic edge_case(input logic lvl, input logic [DW-1:0] e);
      wr(OFS_CNT1, 16'h0010);
      timer_pin_a_in <= lvl;
      repeat (8) @(posedge clk_sys);
      chk_rd("cnt1_edge", OFS_CNT1, e);
   endtask

   initial begin
      do_reset();
      chk_rd("mode_rst", OFS_MODE, {8'h00, MODE_RST});
      chk_rd("ictl_rst", OFS_ICTL, {8'h00, ICTL_RST});
      chk_rd("iclr_rd", OFS_ICLR, 16'h00ff);
      chk_rd("unmapped", 8'h52, RD_NONE);
      `CHK("oe_rst", 1'b1, timer_pin_a_oe_n)
      `CHK("irq_rst", 2'b00, {timer_irq_1, timer_irq_2})
      $display("test reset done");

      // Interrupt control with counters stopped
      wr(OFS_MODE, 16'h0080);
      wr(OFS_ICTL, 16'h000f);
      chk_rd("pend_sw_set", OFS_ICTL, 16'h000f);
      `CHK("irq_masked", 2'b00, {timer_irq_1, timer_irq_2})
      wr(OFS_ICTL, 16'h0000);
      chk_rd("pend_zero_ign", OFS_ICTL, 16'h000f);
      wr(OFS_ICTL, 16'h0010);
      @(negedge clk_sys);
      `CHK("irq_a_only", 2'b10, {timer_irq_1, timer_irq_2})
      wr(OFS_ICTL, 16'h00f0);
      wr(OFS_ICLR, 16'h0000);
      chk_rd("clr_zero", OFS_ICTL, 16'h00ff);
      chk_rd("iclr_rd2", OFS_ICLR, 16'h00ff);
      pend = 4'hf;
      for (int i = 0; i < NSRC; i++) begin
         wr(OFS_ICLR, 16'h0001 << i);
         pend[i] = 1'b0;
         chk_rd("clr_bit", OFS_ICTL, {8'h00, 4'hf, pend});
         `CHK("irq1", |pend[2:0], timer_irq_1)
         `CHK("irq2", pend[3], timer_irq_2)
      end
      $display("test interrupts done");

      // Pin direction for every mode code
      for (int m = 0; m < 4; m++) begin
         wr(OFS_MODE, 16'h0090 | m);
         @(negedge clk_sys);
         `CHK("oe_mode", (m == 1), timer_pin_a_oe_n)
      end
      wr(OFS_MODE, 16'h0082);
      @(negedge clk_sys);
      `CHK("oe_pen_off", 1'b1, timer_pin_a_oe_n)
      $display("test modes done");

      // Dual counter mode, pin toggles on counter one underflow
      wr(OFS_CKSEL, 16'h0000);
      wr(OFS_PRSC, 16'h0000);
      wr(OFS_RLDA, 16'h0003);
      wr(OFS_CNT1, 16'h0003);
      wr(OFS_RLDB, 16'h0002);
      wr(OFS_CNT2, 16'h0002);
      chk_rd("rlda", OFS_RLDA, 16'h0003);
      chk_rd("rldb", OFS_RLDB, 16'h0002);
      wr(OFS_MODE, 16'h00d2);
      @(negedge clk_sys);
      `CHK("pin_start", 2'b10, {timer_pin_a_out, timer_pin_a_oe_n})
      wr(OFS_CKSEL, {10'h000, CK_SLOW, CK_PRSC});
      wait_pin(1'b0);
      wait_pin(1'b1);
      repeat (200) @(posedge clk_sys);
      rd(OFS_ICTL, v);
      `CHK("pend_a_d", 16'h0009, v & 16'h0009)
      wr(OFS_CKSEL, 16'h0000);
      $display("test counting done");

      // PWM mode, reloads alternate A then B, events A then B
      wr(OFS_ICLR, 16'h000f);
      wr(OFS_MODE, 16'h0090);
      wr(OFS_CKSEL, {13'h0000, CK_PRSC});
      repeat (40) @(posedge clk_sys);
      wr(OFS_CKSEL, 16'h0000);
      rd(OFS_ICTL, v);
      `CHK("pend_a_b", 16'h0003, v & 16'h0003)
      `CHK("irq1_pwm", 1'b1, timer_irq_1)
      $display("test pwm mode done");

      // Capture mode presets counter one on the chosen edge
      wr(OFS_ICLR, 16'h000f);
      wr(OFS_MODE, 16'h00d5);
      @(negedge clk_sys);
      `CHK("oe_capture", 1'b1, timer_pin_a_oe_n)
      edge_case(1'b1, CNT_PRESET);
      rd(OFS_ICTL, v);
      `CHK("pend_a_cap", 16'h0001, v & 16'h0001)
      edge_case(1'b0, 16'h0010);
      wr(OFS_MODE, 16'h0091);
      edge_case(1'b1, 16'h0010);
      edge_case(1'b0, CNT_PRESET);
      $display("test capture done");

      // Mode register mask, then disable effects
      wr(OFS_MODE, 16'h00ff);
      chk_rd("mode_mask", OFS_MODE, {8'h00, MODE_MASK});
      wr(OFS_ICTL, 16'h00ff);
      wr(OFS_MODE, 16'h0000);
      chk_rd("dis_pend", OFS_ICTL, 16'h00f0);
      `CHK("dis_oe", 1'b1, timer_pin_a_oe_n)
      wr(OFS_RLDA, 16'h5678);
      wr(OFS_CNT1, 16'h1234);
      wr(OFS_ICTL, 16'h000f);
      chk_rd("dis_rlda", OFS_RLDA, 16'h0010);
      chk_rd("dis_cnt1", OFS_CNT1, CNT_PRESET);
      chk_rd("dis_ictl", OFS_ICTL, 16'h0000);
      $display("test disable done");

      // Second reset keeps data registers
      do_reset();
      chk_rd("rst_rlda", OFS_RLDA, 16'h0010);
      chk_rd("rst_rldb", OFS_RLDB, 16'h0002);
      chk_rd("rst_ictl", OFS_ICTL, 16'h0000);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule
